// >>> dv/agrc_seek_model.sv
`timescale 1ns/1ps
module agrc_seek_model
(
	input  wire logic       ref_clk_i,
	input  wire logic       srst_i,
	input  wire logic       seek_req_i,
	input  wire logic [7:0] delay_i,
	input  wire logic       fail_i,
	output logic            seek_done_o,
	output logic            seek_fail_o
);
	logic       moving_r;
	logic [7:0] cnt_r;

	// ==================================================
	// Head seek toward cylinder zero
	// seek, completion, failure
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			moving_r    <= 1'b0;
			cnt_r       <= 8'h00;
			seek_done_o <= 1'b0;
			seek_fail_o <= 1'b0;
		end
		else
		begin
			seek_done_o <= 1'b0;
			// After the done pulse the fault line toggles to the inverse of the value it reported
			if (seek_done_o)
				seek_fail_o <= ~seek_fail_o;
			if (seek_req_i)
			begin
				moving_r <= 1'b1;
				cnt_r    <= delay_i;
			end
			else if (moving_r && cnt_r == 8'h00)
			begin
				moving_r    <= 1'b0;
				seek_done_o <= 1'b1;
				seek_fail_o <= fail_i;
			end
			else if (moving_r)
				cnt_r <= cnt_r - 8'h01;
		end
	end
endmodule

// >>> dv/agrc_top_tb.sv
`timescale 1ns/1ps
module agrc_top_tb;
	logic        ref_clk_i;
	logic        srst_i;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        seek_done;
	logic        seek_fail;
	logic        seek_req;
	logic        busy;
	logic        intrq;
	logic [7:0]  seek_dly;
	logic        seek_bad;
	logic [32:0] exp_q[$];
	logic [32:0] e;
	logic [31:0] tot;
	logic [31:0] cyl;
	logic [31:0] fe;
	logic [31:0] sec;
	logic [15:0] e85;
	logic [15:0] e88;
	logic [7:0]  spt;
	logic [3:0]  hd;
	int          n_fail;
	int          total_checks;
	int          n_seek;

	agrc_top u_agrc_top
	(
		.ref_clk_i   (ref_clk_i),
		.srst_i      (srst_i),
		.psel_i      (psel),
		.penable_i   (penable),
		.pwrite_i    (pwrite),
		.paddr_i     (paddr),
		.pwdata_i    (pwdata),
		.prdata_o    (prdata),
		.pready_o    (pready),
		.pslverr_o   (pslverr),
		.seek_done_i (seek_done),
		.seek_fail_i (seek_fail),
		.seek_req_o  (seek_req),
		.busy_o      (busy),
		.intrq_o     (intrq)
	);

	agrc_seek_model u_agrc_seek_model
	(
		.ref_clk_i   (ref_clk_i),
		.srst_i      (srst_i),
		.seek_req_i  (seek_req),
		.delay_i     (seek_dly),
		.fail_i      (seek_bad),
		.seek_done_o (seek_done),
		.seek_fail_o (seek_fail)
	);

	initial
	begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	// ==================================================
	// Checking and closing
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] x);
		total_checks++;
		if (seen !== x)
		begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", nm, x, seen);
		end
	endtask

	task results();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	always @(posedge ref_clk_i)
	begin
		if (seek_req === 1'b1)
			n_seek++;
		if (psel && penable && pready === 1'b1)
		begin
			e = exp_q.pop_front();
			chk("prdata", prdata, e[31:0]);
			chk("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
		end
	end

	// ==================================================
	// Bus transfers
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] x);
		int n;
		exp_q.push_back(x);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk_i);
		penable <= 1'b1;
		for (n = 0; n < 16; n++)
		begin
			@(posedge ref_clk_i);
			if (pready === 1'b1)
				break;
		end
		if (n == 16)
		begin
			n_fail++;
			results();
		end
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk_i);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0, {1'b0, x});
	endtask

	task idw(input logic [7:0] w, input logic [15:0] x);
		wr(agrc_pkg::ADDR_IDIDX, {24'h0, w});
		rd(agrc_pkg::ADDR_IDDATA, {16'h0, x});
	endtask

	// Busy must be seen first, then the interrupt once busy is gone
	task wait_done(input logic [31:0] st);
		int   n;
		logic saw;
		saw = 1'b0;
		for (n = 0; n < 200; n++)
		begin
			@(posedge ref_clk_i);
			if (busy === 1'b1)
				saw = 1'b1;
			if (intrq === 1'b1)
				break;
		end
		if (n == 200)
		begin
			n_fail++;
			results();
		end
		chk("busy_seen", {31'h0, saw}, 32'h1);
		chk("busy_at_irq", {31'h0, busy}, 32'h0);
		rd(agrc_pkg::ADDR_STATUS, st);
		@(posedge ref_clk_i);
		chk("intrq_clear", {31'h0, intrq}, 32'h0);
	endtask

	// ==================================================
	// Main sequence
	initial
	begin
		srst_i = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		seek_dly = 8'h00;
		seek_bad = 1'b0;
		n_fail = 0;
		total_checks = 0;
		n_seek = 0;
		void'($urandom(4));
		repeat (10) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		@(posedge ref_clk_i);
		rd(agrc_pkg::ADDR_TOTAL, agrc_pkg::TOTAL_RST);
		rd(agrc_pkg::ADDR_FEATEN, 32'h0);
		rd(agrc_pkg::ADDR_STATUS, 32'h0);
		rd(agrc_pkg::ADDR_CMD, 32'h0);
		apb(1'b0, 8'h2C, 32'h0, {1'b1, 32'h0});
		apb(1'b1, 8'h2C, 32'h5A, {1'b1, 32'h0});
		for (int i = 0; i < 4; i++)
		begin
			seek_bad <= i[0];
			seek_dly <= (i < 2) ? 8'h00 : 8'($urandom_range(100, 20));
			wr(agrc_pkg::ADDR_CMD, {24'h0, agrc_pkg::CMD_RECAL});
			wait_done({31'h0, i[0]});
			rd(agrc_pkg::ADDR_ERROR, {30'h0, i[0], 1'b0});
		end
		chk("seek_reqs", n_seek, 32'h4);
		for (int i = 0; i < 6; i++)
		begin
			tot = $urandom() >> 8;
			spt = 8'($urandom_range(255, 1));
			hd = 4'($urandom_range(15, 0));
			if (i == 0)
			begin
				tot = 32'hFFFF_FFFF;
				spt = 8'h01;
				hd = 4'h0;
			end
			if (i == 1)
				spt = 8'h00;
			cyl = 32'hFFFF;
			if (spt != 8'h00)
				cyl = tot / ({24'h0, spt} * ({28'h0, hd} + 32'h1));
			if (cyl > 32'hFFFF)
				cyl = 32'hFFFF;
			wr(agrc_pkg::ADDR_TOTAL, tot);
			wr(agrc_pkg::ADDR_SECCNT, {24'h0, spt});
			wr(agrc_pkg::ADDR_DRVHEAD, {28'h0, hd});
			wr(agrc_pkg::ADDR_CMD, {24'h0, agrc_pkg::CMD_INIT_GEOM});
			wait_done(32'h0);
			rd(agrc_pkg::ADDR_ERROR, 32'h0);
			rd(agrc_pkg::ADDR_CYL, cyl);
			idw(agrc_pkg::IDW_54, cyl[15:0]);
			idw(agrc_pkg::IDW_55, {12'h0, hd} + 16'h1);
			idw(agrc_pkg::IDW_56, {8'h0, spt});
		end
		for (int i = 0; i < 4; i++)
		begin
			fe = $urandom() & 32'h0000_073F;
			sec = $urandom() & 32'h0000_FFFF;
			if (i == 0)
				fe = 32'h0000_0600;
			e85 = {1'b0, fe[0], 3'h0, fe[1], 3'h0, fe[2], fe[3], 1'b0,
				fe[4], 3'h0};
			e88 = 16'h003F;
			if (fe[10:8] <= 3'h5)
				e88[8 + fe[10:8]] = 1'b1;
			wr(agrc_pkg::ADDR_FEATEN, fe);
			wr(agrc_pkg::ADDR_SECUR, sec);
			idw(agrc_pkg::IDW_53, 16'h0004);
			idw(agrc_pkg::IDW_82, agrc_pkg::W82_VAL);
			idw(agrc_pkg::IDW_83, 16'h4200);
			idw(agrc_pkg::IDW_84, 16'h4000);
			idw(agrc_pkg::IDW_85, e85);
			idw(agrc_pkg::IDW_86, {6'h0, fe[5], 9'h0});
			idw(agrc_pkg::IDW_88, e88);
			idw(agrc_pkg::IDW_128, sec[15:0] & 16'h011E);
			idw(8'h57, 16'h0000);
		end
		srst_i <= 1'b1;
		repeat (10) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		@(posedge ref_clk_i);
		idw(agrc_pkg::IDW_85, 16'h0000);
		idw(agrc_pkg::IDW_128, 16'h0000);
		results();
	end
endmodule

// >>> src/agrc_div.sv
`timescale 1ns/1ps
module agrc_div
(
	input  wire logic  ref_clk_i,
	input  wire logic  srst_i,
	agrc_div_if.slave  dv
);

	typedef struct packed {
		logic        run;
		logic [5:0]  cnt;
		logic [12:0] rem;
		logic [31:0] quo;
		logic        done;
		logic [15:0] res;
	} agrc_div_s;

	agrc_div_s st;
	agrc_div_s nx;
	logic [12:0] rem_sh;

	// ==================================================
	// Restoring divider, one quotient bit per clock
	always_comb
	begin
		nx = st;
		nx.done = 1'b0;
		rem_sh = {st.rem[11:0], st.quo[31]};
		if (dv.start)
		begin
			nx.run = 1'b1;
			nx.cnt = 6'(agrc_pkg::DIV_STEPS);
			nx.rem = 13'h0000;
			nx.quo = dv.dividend;
		end
		else if (st.run)
		begin
			nx.quo = {st.quo[30:0], 1'b0};
			nx.rem = rem_sh;
			if (rem_sh >= {1'b0, dv.divisor})
			begin
				nx.rem = rem_sh - {1'b0, dv.divisor};
				nx.quo[0] = 1'b1;
			end
			nx.cnt = st.cnt - 6'h01;
			if (st.cnt == 6'h01)
			begin
				nx.run = 1'b0;
				nx.done = 1'b1;
				nx.res = (|nx.quo[31:16]) ? agrc_pkg::CYL_MAX
					: nx.quo[15:0];
			end
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
			st <= '0;
		else
			st <= nx;
	end

	assign dv.done = st.done;
	assign dv.quotient = st.res;

	// ==================================================
	// Checks
	a_quot_clamp: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		st.run && st.cnt == 6'h01 && |nx.quo[31:16]
		|=> dv.done && dv.quotient == 16'hFFFF)
		else $error("cylinder count not clamped");

endmodule

// >>> src/agrc_div_if.sv
`timescale 1ns/1ps
interface agrc_div_if;
	logic        start;
	logic [31:0] dividend;
	logic [11:0] divisor;
	logic        done;
	logic [15:0] quotient;

	modport master (output start, output dividend, output divisor,
		input done, input quotient);
	modport slave (input start, input dividend, input divisor,
		output done, output quotient);
endinterface

// >>> src/agrc_pkg.sv
package agrc_pkg;

	// ==================================================
	// Register byte offsets
	localparam logic [7:0] ADDR_CMD     = 8'h00;
	localparam logic [7:0] ADDR_SECCNT  = 8'h04;
	localparam logic [7:0] ADDR_DRVHEAD = 8'h08;
	localparam logic [7:0] ADDR_STATUS  = 8'h0C;
	localparam logic [7:0] ADDR_ERROR   = 8'h10;
	localparam logic [7:0] ADDR_CYL     = 8'h14;
	localparam logic [7:0] ADDR_TOTAL   = 8'h18;
	localparam logic [7:0] ADDR_FEATEN  = 8'h1C;
	localparam logic [7:0] ADDR_SECUR   = 8'h20;
	localparam logic [7:0] ADDR_IDIDX   = 8'h24;
	localparam logic [7:0] ADDR_IDDATA  = 8'h28;

	// ==================================================
	// Command codes
	localparam logic [7:0] CMD_INIT_GEOM = 8'h91;
	localparam logic [7:0] CMD_RECAL     = 8'h10;

	// ==================================================
	// Field positions
	localparam int STAT_BSY   = 7;
	localparam int STAT_ERR   = 0;
	localparam int ERR_TRK0   = 1;
	localparam int FE_NOP     = 0;
	localparam int FE_HPA     = 1;
	localparam int FE_LOOK    = 2;
	localparam int FE_WCACHE  = 3;
	localparam int FE_PM      = 4;
	localparam int FE_AAM     = 5;
	localparam int FE_UDMA_LO = 8;
	localparam int W85_NOP    = 14;
	localparam int W85_HPA    = 10;
	localparam int W85_LOOK   = 6;
	localparam int W85_WCACHE = 5;
	localparam int W85_PM     = 3;
	localparam int W86_AAM    = 9;

	// ==================================================
	// Identify words and fixed contents
	localparam logic [7:0]  IDW_53  = 8'h35;
	localparam logic [7:0]  IDW_54  = 8'h36;
	localparam logic [7:0]  IDW_55  = 8'h37;
	localparam logic [7:0]  IDW_56  = 8'h38;
	localparam logic [7:0]  IDW_82  = 8'h52;
	localparam logic [7:0]  IDW_83  = 8'h53;
	localparam logic [7:0]  IDW_84  = 8'h54;
	localparam logic [7:0]  IDW_85  = 8'h55;
	localparam logic [7:0]  IDW_86  = 8'h56;
	localparam logic [7:0]  IDW_88  = 8'h58;
	localparam logic [7:0]  IDW_128 = 8'h80;
	localparam logic [15:0] W53_VAL = 16'h0004;
	localparam logic [15:0] W82_VAL = 16'h4468;
	localparam logic [15:0] W83_VAL = 16'h4200;
	localparam logic [15:0] W84_VAL = 16'h4000;
	localparam logic [15:0] SEC_MASK = 16'h011E;

	// ==================================================
	// Reset values and limits
	localparam logic [15:0] CYL_MAX    = 16'hFFFF;
	localparam logic [15:0] FEATEN_RST = 16'h0000;
	localparam logic [15:0] SECUR_RST  = 16'h0000;
	localparam logic [31:0] TOTAL_RST  = 32'h0100_0000;
	localparam int          DIV_STEPS  = 32;

endpackage

// >>> src/agrc_top.sv
`timescale 1ns/1ps
module agrc_top
#(
	parameter int unsigned UDMA_MAX = 5
)
(
	input  wire logic        ref_clk_i,
	input  wire logic        srst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        seek_done_i,
	input  wire logic        seek_fail_i,
	output logic             seek_req_o,
	output logic             busy_o,
	output logic             intrq_o
);

	if (UDMA_MAX > 5)
		$error("UDMA_MAX above 5 is not supported");

	typedef enum logic [2:0] {
		S_IDLE,
		S_INIT_SAVE,
		S_INIT_CALC,
		S_RECAL_WAIT,
		S_UNBUSY,
		S_IRQ
	} agrc_state_e;

	typedef struct packed {
		agrc_state_e state;
		logic [7:0]  seccnt;
		logic [3:0]  drvhead;
		logic [7:0]  spt;
		logic [3:0]  maxhd;
		logic [15:0] cyl;
		logic [31:0] total;
		logic [15:0] featen;
		logic [15:0] secur;
		logic [7:0]  ididx;
		logic        bsy;
		logic        err;
		logic        trk0;
		logic        intrq;
		logic        seek_req;
		logic        div_start;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} agrc_top_s;

	agrc_top_s   st;
	agrc_top_s   nx;
	logic [15:0] id_word;
	logic [31:0] rd_data;
	logic        rd_hit;
	logic        setup;
	logic        acc;
	logic        wr;
	logic [2:0]  udma_sel;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);

	agrc_div_if dv ();

	agrc_div u_div
	(
		.ref_clk_i (ref_clk_i),
		.srst_i    (srst_i),
		.dv        (dv)
	);

	// ==================================================
	// Divider feed
	// always translate
	assign dv.dividend = st.total;
	assign dv.divisor = 12'(st.spt) * (12'(st.maxhd) + 12'h001);
	assign dv.start = st.div_start;

	// ==================================================
	// Identify word generation
	assign udma_sel = st.featen[agrc_pkg::FE_UDMA_LO +: 3];

	always_comb
	begin
		id_word = 16'h0000;
		case (st.ididx)
			agrc_pkg::IDW_53: id_word = agrc_pkg::W53_VAL;
			agrc_pkg::IDW_54: id_word = st.cyl;
			agrc_pkg::IDW_55: id_word = 16'(st.maxhd) + 16'h0001;
			agrc_pkg::IDW_56: id_word = 16'(st.spt);
			agrc_pkg::IDW_82: id_word = agrc_pkg::W82_VAL;
			agrc_pkg::IDW_83: id_word = agrc_pkg::W83_VAL;
			agrc_pkg::IDW_84: id_word = agrc_pkg::W84_VAL;
			agrc_pkg::IDW_85:
			begin
				id_word[agrc_pkg::W85_NOP] = st.featen[agrc_pkg::FE_NOP];
				id_word[agrc_pkg::W85_HPA] = st.featen[agrc_pkg::FE_HPA];
				id_word[agrc_pkg::W85_LOOK] = st.featen[agrc_pkg::FE_LOOK];
				id_word[agrc_pkg::W85_WCACHE] =
					st.featen[agrc_pkg::FE_WCACHE];
				id_word[agrc_pkg::W85_PM] = st.featen[agrc_pkg::FE_PM];
			end
			agrc_pkg::IDW_86:
				id_word[agrc_pkg::W86_AAM] = st.featen[agrc_pkg::FE_AAM];
			agrc_pkg::IDW_88:
			begin
				if (32'(udma_sel) <= UDMA_MAX)
					id_word[13:8] = 6'(7'h01 << udma_sel);
				id_word[5:0] = 6'((7'h02 << UDMA_MAX) - 7'h01);
			end
			agrc_pkg::IDW_128: id_word = st.secur & agrc_pkg::SEC_MASK;
			default: id_word = 16'h0000;
		endcase
	end

	// ==================================================
	// Register read decode
	always_comb
	begin
		rd_data = 32'h0000_0000;
		rd_hit = 1'b1;
		case (paddr_i)
			agrc_pkg::ADDR_CMD: rd_data = 32'h0000_0000;
			agrc_pkg::ADDR_SECCNT: rd_data = 32'(st.seccnt);
			agrc_pkg::ADDR_DRVHEAD: rd_data = 32'(st.drvhead);
			agrc_pkg::ADDR_STATUS:
			begin
				rd_data[agrc_pkg::STAT_BSY] = st.bsy;
				rd_data[agrc_pkg::STAT_ERR] = st.err;
			end
			agrc_pkg::ADDR_ERROR: rd_data[agrc_pkg::ERR_TRK0] = st.trk0;
			agrc_pkg::ADDR_CYL: rd_data = 32'(st.cyl);
			agrc_pkg::ADDR_TOTAL: rd_data = st.total;
			agrc_pkg::ADDR_FEATEN: rd_data = 32'(st.featen);
			agrc_pkg::ADDR_SECUR: rd_data = 32'(st.secur);
			agrc_pkg::ADDR_IDIDX: rd_data = 32'(st.ididx);
			agrc_pkg::ADDR_IDDATA: rd_data = 32'(id_word);
			default: rd_hit = 1'b0;
		endcase
	end

	assign setup = psel_i && !penable_i;
	assign acc = psel_i && penable_i && st.pready;
	assign wr = acc && pwrite_i && !st.pslverr;

	// ==================================================
	// Next state
	always_comb
	begin
		nx = st;
		nx.pready = 1'b0;
		nx.pslverr = 1'b0;
		nx.div_start = 1'b0;
		nx.seek_req = 1'b0;
		if (setup)
		begin
			nx.pready = 1'b1;
			nx.pslverr = !rd_hit;
			nx.prdata = pwrite_i ? 32'h0000_0000 : rd_data;
		end
		if (wr)
		begin
			case (paddr_i)
				agrc_pkg::ADDR_SECCNT: nx.seccnt = pwdata_i[7:0];
				agrc_pkg::ADDR_DRVHEAD: nx.drvhead = pwdata_i[3:0];
				agrc_pkg::ADDR_TOTAL: nx.total = pwdata_i;
				agrc_pkg::ADDR_FEATEN: nx.featen = pwdata_i[15:0];
				agrc_pkg::ADDR_SECUR: nx.secur = pwdata_i[15:0];
				agrc_pkg::ADDR_IDIDX: nx.ididx = pwdata_i[7:0];
				default: nx.ididx = st.ididx;
			endcase
		end
		if (acc && !pwrite_i && paddr_i == agrc_pkg::ADDR_STATUS)
			nx.intrq = 1'b0;
		case (st.state)
			S_IDLE:
			begin
				if (wr && paddr_i == agrc_pkg::ADDR_CMD)
				begin
					if (pwdata_i[7:0] == agrc_pkg::CMD_INIT_GEOM)
					begin
						nx.bsy = 1'b1;
						nx.intrq = 1'b0;
						nx.state = S_INIT_SAVE;
					end
					else if (pwdata_i[7:0] == agrc_pkg::CMD_RECAL)
					begin
						nx.bsy = 1'b1;
						nx.intrq = 1'b0;
						nx.seek_req = 1'b1;
						nx.state = S_RECAL_WAIT;
					end
				end
			end
			S_INIT_SAVE:
			begin
				nx.spt = st.seccnt;
				nx.maxhd = st.drvhead;
				nx.div_start = 1'b1;
				nx.state = S_INIT_CALC;
			end
			S_INIT_CALC:
			begin
				if (dv.done)
				begin
					nx.cyl = dv.quotient;
					nx.err = 1'b0;
					nx.trk0 = 1'b0;
					nx.state = S_UNBUSY;
				end
			end
			S_RECAL_WAIT:
			begin
				if (seek_done_i)
				begin
					nx.err = seek_fail_i;
					nx.trk0 = seek_fail_i;
					nx.state = S_UNBUSY;
				end
			end
			S_UNBUSY:
			begin
				nx.bsy = 1'b0;
				nx.state = S_IRQ;
			end
			S_IRQ:
			begin
				nx.intrq = 1'b1;
				nx.state = S_IDLE;
			end
			default: nx.state = S_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			st <= '0;
			st.state <= S_IDLE;
			st.total <= agrc_pkg::TOTAL_RST;
			st.featen <= agrc_pkg::FEATEN_RST;
			st.secur <= agrc_pkg::SECUR_RST;
		end
		else
			st <= nx;
	end

	assign prdata_o = st.prdata;
	assign pready_o = st.pready;
	assign pslverr_o = st.pslverr;
	assign seek_req_o = st.seek_req;
	assign busy_o = st.bsy;
	assign intrq_o = st.intrq;

	// ==================================================
	// Checks

	logic cmd_init;
	logic cmd_recal;
	assign cmd_init = wr && paddr_i == agrc_pkg::ADDR_CMD
		&& st.state == S_IDLE && pwdata_i[7:0] == agrc_pkg::CMD_INIT_GEOM;
	assign cmd_recal = wr && paddr_i == agrc_pkg::ADDR_CMD
		&& st.state == S_IDLE && pwdata_i[7:0] == agrc_pkg::CMD_RECAL;

	a_init_busy: assert property (cmd_init |=> busy_o ##1 busy_o
		&& st.spt == $past(st.seccnt) && st.maxhd == $past(st.drvhead))
		else $error("init did not go busy and save parameters");
	a_init_order: assert property (st.state == S_INIT_CALC
		&& dv.done |=> busy_o && st.cyl == $past(dv.quotient)
		##1 !busy_o && !intrq_o ##1 intrq_o)
		else $error("init completion order wrong");
	a_recal_seek: assert property (cmd_recal
		|=> busy_o && seek_req_o ##1 !seek_req_o)
		else $error("recalibrate did not start seek");
	a_recal_done: assert property (st.state == S_RECAL_WAIT
		&& seek_done_i |=> busy_o ##1 !busy_o ##1 intrq_o)
		else $error("recalibrate completion order wrong");
	a_trk0_err: assert property (st.state == S_RECAL_WAIT
		&& seek_done_i |=> st.err == $past(seek_fail_i)
		&& st.trk0 == $past(seek_fail_i))
		else $error("track zero error not reported");
	a_irq_after_bsy: assert property ($rose(intrq_o)
		|-> !busy_o && !$past(busy_o))
		else $error("interrupt before busy released");
	a_word84_val: assert property (setup && !pwrite_i
		&& paddr_i == agrc_pkg::ADDR_IDDATA
		&& st.ididx == agrc_pkg::IDW_84 |=> prdata_o == 32'h0000_4000)
		else $error("word 84 wrong");
	a_word53_udma: assert property (setup && !pwrite_i
		&& paddr_i == agrc_pkg::ADDR_IDDATA
		&& st.ididx == agrc_pkg::IDW_53 |=> prdata_o[2])
		else $error("word 53 bit 2 clear");
	a_word88_onehot: assert property (setup && !pwrite_i
		&& paddr_i == agrc_pkg::ADDR_IDDATA
		&& st.ididx == agrc_pkg::IDW_88 && 32'(udma_sel) <= UDMA_MAX
		|=> $onehot(prdata_o[13:8]))
		else $error("word 88 selection not one-hot");
	a_word83_valid: assert property (setup && !pwrite_i
		&& paddr_i == agrc_pkg::ADDR_IDDATA
		&& st.ididx == agrc_pkg::IDW_83
		|=> prdata_o[9] && prdata_o[15:0] != 16'hFFFF)
		else $error("word 83 invalid");

	c_init_done: cover property (st.state == S_INIT_CALC && dv.done);
	c_recal_fail: cover property (st.state == S_RECAL_WAIT
		&& seek_done_i && seek_fail_i);
	c_recal_pass: cover property (st.state == S_RECAL_WAIT
		&& seek_done_i && !seek_fail_i);
	c_cyl_clamp: cover property (dv.done && dv.quotient == 16'hFFFF);

endmodule
